// ---- shp_host_port.sv ----
// SRAM-like host port: strobe sync, decode, 16/32 packing, irq pin
//
// Overview of operation
// - Seven-bit word address selects CSR or queue
// - Read strobe with select drives data bus
// - Write strobe with select captures data bus
// - Strobes ignored without chip select
// - Selected write leaves reduced power state
// - Interrupt polarity, sources, driver type configurable
// - Queue select steers reads RX, writes TX
// - Queue select ignores six upper address lines
// - Writes refused until first read after reset/wake
// - Any selected write wakes, whatever data
// - Pack halves into 32-bit words, split back
`timescale 1ns/100ps
module shp_host_port
    import shp_pkg::*;
#(
    parameter int DEPTH = SHP_FIFO_DEPTH
) (
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic [SHP_ADDR_W-1:0] addr,
    input wire logic [SHP_HDATA_W-1:0] data_in,
    output logic [SHP_HDATA_W-1:0] data_out,
    output logic data_oe,
    input wire logic read_strobe_n,
    input wire logic write_strobe_n,
    input wire logic chip_select_n,
    input wire logic queue_sel,
    input wire logic [SHP_IRQ_SRC_W-1:0] irq_src,
    output logic irq_out,
    output logic irq_oe,
    output logic low_power,
    output logic [SHP_WORD_W-1:0] tx_data,
    output logic tx_valid,
    input wire logic tx_ready,
    input wire logic [SHP_WORD_W-1:0] rx_data,
    input wire logic rx_valid,
    output logic rx_ready
);
    shp_host_ctl_t s1_q, s2_q, s3_q;
    shp_state_t st_q, st_d;
    logic [15:0] dout_q, dout_d;
    logic [15:0] txlo_q, txlo_d;
    logic [15:0] irq_cfg_q, irq_cfg_d;
    logic pwr_q, pwr_d, rd_seen_q, rd_seen_d;
    logic [SHP_WORD_W-1:0] txw_d;
    logic txw_v;
    logic rd_lvl, wr_lvl, rd_go, wr_go, is_queue, ev_wake;
    logic [6:0] eff_addr;
    logic [SHP_WORD_W-1:0] rxw;
    logic rxw_v, txf_ready, irq_act;

    // Two-stage sync of the whole control group
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            s1_q <= '{rd_n: 1'b1, wr_n: 1'b1, cs_n: 1'b1, qsel: 1'b0, addr: 7'h00};
            s2_q <= '{rd_n: 1'b1, wr_n: 1'b1, cs_n: 1'b1, qsel: 1'b0, addr: 7'h00};
            s3_q <= '{rd_n: 1'b1, wr_n: 1'b1, cs_n: 1'b1, qsel: 1'b0, addr: 7'h00};
        end else begin
            s1_q <= '{rd_n: read_strobe_n, wr_n: write_strobe_n, cs_n: chip_select_n,
                      qsel: queue_sel, addr: addr};
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    assign rd_lvl = !s2_q.rd_n && !s2_q.cs_n;
    assign wr_lvl = !s2_q.wr_n && !s2_q.cs_n;
    assign rd_go = rd_lvl && (s3_q.rd_n || s3_q.cs_n);
    assign wr_go = wr_lvl && (s3_q.wr_n || s3_q.cs_n);
    // Upper lines masked in queue mode
    assign eff_addr = s2_q.qsel ? {6'h00, s2_q.addr[SHP_QSEL_KEEP_LSB]} : s2_q.addr;
    assign is_queue = (shp_decode(s2_q.qsel, eff_addr) == 2'h1);
    assign ev_wake = wr_go && pwr_q;

    always_comb begin
        st_d = st_q;
        dout_d = dout_q;
        txlo_d = txlo_q;
        irq_cfg_d = irq_cfg_q;
        pwr_d = pwr_q;
        rd_seen_d = rd_seen_q;
        txw_d = '0;
        txw_v = 1'b0;
        rx_ready = 1'b0;
        case (st_q)
            SHP_ST_IDLE: begin
                if (ev_wake) begin
                    pwr_d = 1'b0;
                    rd_seen_d = 1'b0;
                    st_d = SHP_ST_WAIT;
                end else if (rd_go && !pwr_q) begin
                    rd_seen_d = 1'b1;
                    st_d = SHP_ST_READ;
                    if (is_queue) begin
                        // Low half first, high half pops the word
                        dout_d = eff_addr[SHP_HALF_BIT] ? rxw[31:16] : rxw[15:0];
                        rx_ready = eff_addr[SHP_HALF_BIT] && rxw_v;
                    end else begin
                        case (eff_addr)
                            SHP_IRQ_CFG_ADDR: dout_d = irq_cfg_q;
                            // Bit 5 flags a full TX queue
                            SHP_IRQ_STS_ADDR: dout_d = {10'h000, !txf_ready, irq_act, irq_src};
                            SHP_PWR_ADDR: dout_d = {15'h0000, pwr_q};
                            SHP_BYTE_TEST_ADDR: dout_d = SHP_BYTE_TEST_VAL;
                            default: dout_d = 16'h0000;
                        endcase
                    end
                end else if (wr_go && rd_seen_q) begin
                    st_d = SHP_ST_WRITE;
                    if (is_queue) begin
                        if (!eff_addr[SHP_HALF_BIT]) begin
                            txlo_d = data_in;
                        end else begin
                            txw_d = {data_in, txlo_q};
                            txw_v = 1'b1;
                        end
                    end else begin
                        case (eff_addr)
                            SHP_IRQ_CFG_ADDR: irq_cfg_d = data_in;
                            SHP_PWR_ADDR: pwr_d = data_in[SHP_PWR_DOWN_BIT];
                            default: ;
                        endcase
                    end
                end
            end
            SHP_ST_READ: st_d = rd_lvl ? SHP_ST_READ : SHP_ST_IDLE;
            SHP_ST_WRITE: st_d = wr_lvl ? SHP_ST_WRITE : SHP_ST_IDLE;
            SHP_ST_WAIT: st_d = wr_lvl ? SHP_ST_WAIT : SHP_ST_IDLE;
            default: st_d = SHP_ST_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            st_q <= SHP_ST_IDLE;
            dout_q <= 16'h0000;
            txlo_q <= 16'h0000;
            irq_cfg_q <= SHP_IRQ_CFG_RST;
            pwr_q <= 1'b0;
            rd_seen_q <= 1'b0;
        end else begin
            st_q <= st_d;
            dout_q <= dout_d;
            txlo_q <= txlo_d;
            irq_cfg_q <= irq_cfg_d;
            pwr_q <= pwr_d;
            rd_seen_q <= rd_seen_d;
        end
    end

    // Bus drive while read strobe and select are low
    assign data_out = dout_q;
    assign data_oe = !read_strobe_n && !chip_select_n;
    assign low_power = pwr_q;

    // Interrupt: enabled sources, polarity, push-pull or open drain
    assign irq_act = |(irq_src & irq_cfg_q[SHP_IRQ_EN_LSB +: SHP_IRQ_SRC_W]);
    assign irq_out = irq_cfg_q[SHP_IRQ_POL_BIT] ? irq_act : !irq_act;
    assign irq_oe = irq_cfg_q[SHP_IRQ_OD_BIT] ? irq_act : 1'b1;

    shp_fifo #(.WIDTH(SHP_WORD_W), .DEPTH(DEPTH)) u_tx_fifo (
        .ref_clk(ref_clk),
        .nrst(nrst),
        .in_data(txw_d),
        .in_valid(txw_v),
        .in_ready(txf_ready),
        .out_data(tx_data),
        .out_valid(tx_valid),
        .out_ready(tx_ready)
    );

    assign rxw = rx_data;
    assign rxw_v = rx_valid;

    property p_cs_idle;
        @(posedge ref_clk) disable iff (!nrst)
        (st_q == SHP_ST_IDLE && s2_q.cs_n) |=> st_q == SHP_ST_IDLE;
    endproperty
    a_cs_idle: assert property (p_cs_idle) else $error("strobe taken without select");

    property p_cs_cfg;
        @(posedge ref_clk) disable iff (!nrst)
        s2_q.cs_n |=> $stable(irq_cfg_q);
    endproperty
    a_cs_cfg: assert property (p_cs_cfg) else $error("csr changed without select");

    property p_wake;
        @(posedge ref_clk) disable iff (!nrst)
        (ev_wake && st_q == SHP_ST_IDLE) |=> !low_power;
    endproperty
    a_wake: assert property (p_wake) else $error("no wake on select write");

    property p_wake_state;
        @(posedge ref_clk) disable iff (!nrst)
        (ev_wake && st_q == SHP_ST_IDLE) |=> (st_q == SHP_ST_WAIT && !rd_seen_q);
    endproperty
    a_wake_state: assert property (p_wake_state) else $error("wake write not consumed");

    property p_first_read;
        @(posedge ref_clk) disable iff (!nrst)
        !rd_seen_q |=> $stable(irq_cfg_q) && $stable(txlo_q) && $stable(pwr_q);
    endproperty
    a_first_read: assert property (p_first_read) else $error("write honoured before read");

    property p_one_access;
        @(posedge ref_clk) disable iff (!nrst)
        txw_v |=> !txw_v;
    endproperty
    a_one_access: assert property (p_one_access) else $error("double access per strobe");

    property p_qsel_wr;
        @(posedge ref_clk) disable iff (!nrst)
        (s2_q.qsel && wr_go && !pwr_q) |=> $stable(irq_cfg_q) && $stable(pwr_q);
    endproperty
    a_qsel_wr: assert property (p_qsel_wr) else $error("queue mode write reached a register");

    property p_qsel_rd;
        @(posedge ref_clk) disable iff (!nrst)
        (s2_q.qsel && rd_go && !pwr_q && st_q == SHP_ST_IDLE && !s2_q.addr[SHP_QSEL_KEEP_LSB])
        |=> {16'h0000, data_out} == ($past(rxw) & 32'h0000_ffff);
    endproperty
    a_qsel_rd: assert property (p_qsel_rd) else $error("queue mode read not from rx low half");

    property p_oe;
        @(posedge ref_clk) disable iff (!nrst)
        (read_strobe_n || chip_select_n) |-> !data_oe;
    endproperty
    a_oe: assert property (p_oe) else $error("bus driven outside read");

    property p_pack;
        @(posedge ref_clk) disable iff (!nrst)
        txw_v |-> txw_d[31:16] == data_in;
    endproperty
    a_pack: assert property (p_pack) else $error("high half misplaced");

    property p_irq_od;
        @(posedge ref_clk) disable iff (!nrst)
        (irq_cfg_q[SHP_IRQ_OD_BIT] && !irq_act) |-> !irq_oe;
    endproperty
    a_irq_od: assert property (p_irq_od) else $error("open drain driving idle");

    property p_wr;
        @(posedge ref_clk) disable iff (!nrst)
        (wr_go && !rd_go && rd_seen_q && !pwr_q && st_q == SHP_ST_IDLE) |=> st_q == SHP_ST_WRITE;
    endproperty
    a_wr: assert property (p_wr) else $error("write lost");

    property p_rd;
        @(posedge ref_clk) disable iff (!nrst)
        (rd_go && !pwr_q && !ev_wake && st_q == SHP_ST_IDLE) |=> rd_seen_q;
    endproperty
    a_rd: assert property (p_rd) else $error("read not seen");
endmodule : shp_host_port

// ---- shp_pkg.sv ----
// Package for the SRAM-like host port: constants, types and states
package shp_pkg;

    localparam int SHP_ADDR_W = 7;
    localparam int SHP_HDATA_W = 16;
    localparam int SHP_WORD_W = 32;
    localparam int SHP_FIFO_DEPTH = 16;
    localparam int SHP_SYNC_STAGES = 2;

    // Address decode: word address A[7:1]
    localparam logic [6:0] SHP_RXQ_ADDR = 7'h00;
    localparam logic [6:0] SHP_TXQ_ADDR = 7'h10;
    localparam logic [6:0] SHP_QUEUE_MASK = 7'h70;
    localparam logic [6:0] SHP_CSR_BASE = 7'h20;
    localparam int SHP_HALF_BIT = 0;
    localparam int SHP_QSEL_KEEP_LSB = 0;

    // Control register fields (local CSRs at SHP_IRQ_CFG_ADDR to SHP_BYTE_TEST_ADDR)
    localparam logic [6:0] SHP_IRQ_CFG_ADDR = 7'h20;
    localparam logic [6:0] SHP_IRQ_STS_ADDR = 7'h21;
    localparam logic [6:0] SHP_PWR_ADDR = 7'h22;
    localparam logic [6:0] SHP_BYTE_TEST_ADDR = 7'h23;
    localparam int SHP_IRQ_POL_BIT = 0;
    localparam int SHP_IRQ_OD_BIT = 1;
    localparam int SHP_IRQ_EN_LSB = 4;
    localparam int SHP_IRQ_SRC_W = 4;
    localparam int SHP_PWR_DOWN_BIT = 0;
    localparam logic [15:0] SHP_IRQ_CFG_RST = 16'h0000;
    localparam logic [15:0] SHP_BYTE_TEST_VAL = 16'h4321;

    typedef struct packed {
        logic rd_n;
        logic wr_n;
        logic cs_n;
        logic qsel;
        logic [6:0] addr;
    } shp_host_ctl_t;

    typedef struct packed {
        logic [31:0] data;
        logic valid;
    } shp_word_t;

    typedef enum logic [1:0] {
        SHP_ST_IDLE = 2'b00,
        SHP_ST_READ = 2'b01,
        SHP_ST_WRITE = 2'b10,
        SHP_ST_WAIT = 2'b11
    } shp_state_t;

    // Decode of address into access class, used for read and write
    function automatic logic [1:0] shp_decode(input logic qsel, input logic [6:0] addr);
        if (qsel) begin
            shp_decode = 2'h1;
        end else if ((addr & SHP_QUEUE_MASK) == SHP_RXQ_ADDR) begin
            shp_decode = 2'h1;
        end else if ((addr & SHP_QUEUE_MASK) == SHP_TXQ_ADDR) begin
            shp_decode = 2'h1;
        end else begin
            shp_decode = 2'h2;
        end
    endfunction : shp_decode

endpackage : shp_pkg

// ---- shp_fifo.sv ----
// Parameterised FIFO with registered read data
`timescale 1ns/100ps
module shp_fifo
    import shp_pkg::*;
#(
    parameter int WIDTH = 32,
    parameter int DEPTH = 16
) (
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic [WIDTH-1:0] in_data,
    input wire logic in_valid,
    output logic in_ready,
    output logic [WIDTH-1:0] out_data,
    output logic out_valid,
    input wire logic out_ready
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0] wp_q, wp_d, rp_q, rp_d;
    logic [AW:0] cnt_q, cnt_d;
    logic [WIDTH-1:0] out_q, out_d;
    logic ov_q, ov_d;
    logic push, pop;

    // Output register counts as one of the DEPTH slots
    assign in_ready = (cnt_q + (AW+1)'(ov_q)) != (AW+1)'(DEPTH);
    assign push = in_valid && in_ready;
    assign pop = (cnt_q != '0) && (!ov_q || out_ready);
    assign out_data = out_q;
    assign out_valid = ov_q;

    always_comb begin
        wp_d = push ? wp_q + 1'b1 : wp_q;
        rp_d = pop ? rp_q + 1'b1 : rp_q;
        cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
        out_d = pop ? mem_q[rp_q] : out_q;
        ov_d = pop ? 1'b1 : (out_ready ? 1'b0 : ov_q);
    end

    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            wp_q <= '0;
            rp_q <= '0;
            cnt_q <= '0;
            out_q <= '0;
            ov_q <= 1'b0;
        end else begin
            wp_q <= wp_d;
            rp_q <= rp_d;
            cnt_q <= cnt_d;
            out_q <= out_d;
            ov_q <= ov_d;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (push) begin
            mem_q[wp_q] <= in_data;
        end
    end
endmodule : shp_fifo

// ---- shp_host_model.sv ----
// Host processor model driving the SRAM-like bus
`timescale 1ns/100ps
module shp_host_model
    import shp_pkg::*;
(
    input wire logic ref_clk,
    output logic [SHP_ADDR_W-1:0] addr,
    output logic [SHP_HDATA_W-1:0] data_in,
    input wire logic [SHP_HDATA_W-1:0] data_out,
    input wire logic data_oe,
    output logic read_strobe_n,
    output logic write_strobe_n,
    output logic chip_select_n,
    output logic queue_sel
);
    initial begin
        addr = 7'h00;
        data_in = 16'h0000;
        read_strobe_n = 1'b1;
        write_strobe_n = 1'b1;
        chip_select_n = 1'b1;
        queue_sel = 1'b0;
    end

    // One bus cycle: strobe held 5 cycles, then 4 cycles high
    task automatic access(input logic wr, input logic cs, input logic qs, input logic [6:0] a,
        input logic [15:0] wd, output logic [15:0] rdat, output logic oe);
        @(posedge ref_clk);
        #1;
        addr = a;
        queue_sel = qs;
        data_in = wd;
        chip_select_n = ~cs;
        if (wr) begin
            write_strobe_n = 1'b0;
        end else begin
            read_strobe_n = 1'b0;
        end
        repeat (5) @(posedge ref_clk);
        rdat = data_out;
        oe = data_oe;
        #1;
        read_strobe_n = 1'b1;
        write_strobe_n = 1'b1;
        chip_select_n = 1'b1;
        data_in = ~wd;
        addr = ~a;
        repeat (4) @(posedge ref_clk);
    endtask : access
endmodule : shp_host_model

// ---- testbench.sv ----
// Self-checking testbench of the SRAM-like host port
`timescale 1ns/100ps
module testbench
    import shp_pkg::*;
;
    logic ref_clk = 1'b0;
    logic nrst = 1'b0;
    logic [6:0] addr;
    logic [15:0] data_in, data_out, rd;
    logic data_oe, rs_n, ws_n, cs_n, qsel, irq_out, irq_oe, low_power, oe;
    logic [3:0] irq_src = 4'h0;
    logic [31:0] tx_data;
    logic tx_valid, rx_ready;
    logic tx_ready = 1'b0;
    logic [31:0] rx_data = 32'hffff_ffff;
    logic rx_valid = 1'b0;
    int num_errors = 0;
    int checks = 0;
    int cycles = 0;
    int pops = 0;

    initial begin
        forever #12.5 ref_clk = ~ref_clk;
    end

    shp_host_model u_host (.ref_clk(ref_clk), .addr(addr), .data_in(data_in), .data_out(data_out),
        .data_oe(data_oe), .read_strobe_n(rs_n), .write_strobe_n(ws_n), .chip_select_n(cs_n),
        .queue_sel(qsel));

    shp_host_port u_dut (.ref_clk(ref_clk), .nrst(nrst), .addr(addr), .data_in(data_in),
        .data_out(data_out), .data_oe(data_oe), .read_strobe_n(rs_n), .write_strobe_n(ws_n),
        .chip_select_n(cs_n), .queue_sel(qsel), .irq_src(irq_src), .irq_out(irq_out),
        .irq_oe(irq_oe), .low_power(low_power), .tx_data(tx_data), .tx_valid(tx_valid),
        .tx_ready(tx_ready), .rx_data(rx_data), .rx_valid(rx_valid), .rx_ready(rx_ready));

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic report_and_stop();
        $display("checks %0d num_errors %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : report_and_stop

    task automatic wr(input logic qs, input logic [6:0] a, input logic [15:0] d);
        u_host.access(1'b1, 1'b1, qs, a, d, rd, oe);
    endtask : wr

    task automatic t_refuse_then_read();
        wr(1'b0, 7'h10, 16'h1111);
        wr(1'b0, 7'h11, 16'h2222);
        chk("tx_valid", 32'h0, 32'(tx_valid));
        u_host.access(1'b0, 1'b1, 1'b0, 7'h23, 16'h0, rd, oe);
        chk("byte_test", 32'h4321, 32'(rd));
    endtask : t_refuse_then_read

    task automatic t_no_select();
        u_host.access(1'b0, 1'b0, 1'b0, 7'h23, 16'h0, rd, oe);
        chk("data_oe", 32'h0, 32'(oe));
        u_host.access(1'b1, 1'b0, 1'b1, 7'h00, 16'h1234, rd, oe);
        u_host.access(1'b1, 1'b0, 1'b1, 7'h01, 16'h5678, rd, oe);
        u_host.access(1'b1, 1'b0, 1'b0, 7'h22, 16'h0001, rd, oe);
        chk("tx_valid", 32'h0, 32'(tx_valid));
        chk("low_power", 32'h0, 32'(low_power));
    endtask : t_no_select

    task automatic t_tx_fill_drain();
        for (int i = 0; i < 17; i++) begin
            wr(1'b1, {5'(i * 5 + 3), 2'b00}, 16'(16'h0a05 + i));
            wr(1'b1, {5'(i * 3 + 9), 2'b01}, 16'(16'h5a00 + i));
        end
        u_host.access(1'b0, 1'b1, 1'b0, 7'h21, 16'h0, rd, oe);
        chk("status", 32'h0020, 32'(rd));
        for (int i = 0; i < 16; i++) begin
            @(posedge ref_clk);
            #1;
            chk("tx_valid", 32'h1, 32'(tx_valid));
            chk("tx_data", {16'(16'h5a00 + i), 16'(16'h0a05 + i)}, tx_data);
            tx_ready = 1'b1;
            @(posedge ref_clk);
            #1;
            tx_ready = 1'b0;
            repeat (2) @(posedge ref_clk);
        end
        chk("tx_valid", 32'h0, 32'(tx_valid));
    endtask : t_tx_fill_drain

    task automatic t_rx_read();
        #1;
        rx_data = 32'hc3a5_1e78;
        rx_valid = 1'b1;
        u_host.access(1'b0, 1'b1, 1'b1, 7'h7c, 16'h0, rd, oe);
        chk("rx_low", 32'h1e78, 32'(rd));
        chk("data_oe", 32'h1, 32'(oe));
        u_host.access(1'b0, 1'b1, 1'b1, 7'h5d, 16'h0, rd, oe);
        chk("rx_high", 32'hc3a5, 32'(rd));
        #1;
        rx_valid = 1'b0;
        rx_data = 32'h3c5a_e187;
        chk("rx_pops", 32'h1, 32'(pops));
    endtask : t_rx_read

    task automatic t_irq();
        logic [15:0] cfg[2] = '{16'h0011, 16'h0013};
        for (int m = 0; m < 2; m++) begin
            wr(1'b0, 7'h20, cfg[m]);
            u_host.access(1'b0, 1'b1, 1'b0, 7'h20, 16'h0, rd, oe);
            chk("irq_cfg", 32'(cfg[m]), 32'(rd));
            for (int s = 0; s < 3; s++) begin
                #1;
                irq_src = 4'(s);
                repeat (5) @(posedge ref_clk);
                chk("irq_out", 32'(s == 1), 32'(irq_out));
                chk("irq_oe", 32'(m == 0 || s == 1), 32'(irq_oe));
            end
        end
    endtask : t_irq

    task automatic t_power();
        #1;
        irq_src = 4'h1;
        wr(1'b0, 7'h22, 16'h0001);
        chk("low_power", 32'h1, 32'(low_power));
        wr(1'b0, 7'h23, 16'h0000);
        chk("low_power", 32'h0, 32'(low_power));
        wr(1'b0, 7'h20, 16'h0001);
        chk("irq_out", 32'h1, 32'(irq_out));
        u_host.access(1'b0, 1'b1, 1'b0, 7'h23, 16'h0, rd, oe);
        chk("byte_test", 32'h4321, 32'(rd));
        wr(1'b0, 7'h20, 16'h0001);
        repeat (3) @(posedge ref_clk);
        chk("irq_out", 32'h0, 32'(irq_out));
    endtask : t_power

    always @(posedge ref_clk) begin
        if (rx_ready === 1'b1) begin
            pops++;
        end
        cycles++;
        if (cycles == 20000) begin
            num_errors++;
            report_and_stop();
        end
    end

    initial begin
        repeat (2) @(posedge ref_clk);
        #1;
        nrst = 1'b1;
        repeat (3) @(posedge ref_clk);
        chk("irq_out", 32'h1, 32'(irq_out));
        chk("irq_oe", 32'h1, 32'(irq_oe));
        chk("low_power", 32'h0, 32'(low_power));
        t_refuse_then_read();
        t_no_select();
        t_tx_fill_drain();
        t_rx_read();
        t_irq();
        t_power();
        report_and_stop();
    end
endmodule : testbench
